// ---- logic/sicr_regs.sv ----
// APB register bank of the scan interface: debug readback, start vector, control and interrupts
`timescale 1ns/1ps
module sicr_regs #(
  parameter int NUM_FLAGS = sicr_pkg::NUM_FLAGS
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire sicr_pkg::sicr_observe_s observe,
  input  wire logic [NUM_FLAGS-1:0]    flag_events,
  input  wire logic                    cycle_boundary,
  input  wire logic                    test_cycle_end,
  output logic      [15:0]             start_vector_bits,
  output logic                         scan_module_enable,
  output logic                         test_cycle_insert,
  output logic      [NUM_FLAGS-1:0]    flag_irq,
  output logic                         irq
);
  logic [15:0]          ctl1_reg;
  logic [15:0]          ctl1_next;
  logic [15:0]          vector_reg;
  logic [7:0]           debug_reg;
  logic [2:0]           stat_reg;
  logic [2:0]           stat_next;
  logic [2:0]           mask_reg;
  logic [31:0]          prdata_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;
  logic [NUM_FLAGS-1:0] flag_irq_reg;
  logic                 irq_reg;
  logic                 test_done;
  logic                 test_insert;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Zero wait-state slave: the access phase completes at its first edge
  wire                 access    = psel && penable;
  wire                 wr        = access && pwrite;
  wire                 rd_setup  = psel && !penable && !pwrite;
  wire                 sel_dbg   = hit(paddr, sicr_pkg::OFF_DEBUG);
  wire                 sel_vec   = hit(paddr, sicr_pkg::OFF_VECTOR);
  wire                 sel_ctl   = hit(paddr, sicr_pkg::OFF_CTL1);
  wire                 sel_stat  = hit(paddr, sicr_pkg::OFF_STATUS);
  wire                 sel_mask  = hit(paddr, sicr_pkg::OFF_MASK);
  wire                 mapped    = sel_dbg | sel_vec | sel_ctl | sel_stat | sel_mask;
  wire                 lo_lanes  = pstrb[0] && pstrb[1];
  wire [15:0]          wdata16   = pwdata[15:0];
  wire [NUM_FLAGS-1:0] flags     = ctl1_reg[sicr_pkg::FLAG_LSB +: NUM_FLAGS];
  wire [NUM_FLAGS-1:0] enables   = ctl1_reg[sicr_pkg::EN_LSB +: NUM_FLAGS];
  wire                 ctl_wr    = wr && sel_ctl && lo_lanes;

  // Sticky interrupt events: flag raised, test done, control write with the enable bit zero
  wire [2:0] stat_events = {ctl_wr && !wdata16[sicr_pkg::ENABLE_BIT], test_done,
                            |flag_events};

  // Debug view is chosen by the last mode written
  wire [15:0] dbg_conv = {1'b0, observe.conv_index, 2'b00, observe.conv_data};
  wire [15:0] dbg_bits = {3'b000, observe.seq_index, observe.state_bits};
  wire [15:0] dbg_view = (debug_reg == sicr_pkg::DBG_FETCH)   ? observe.fetch_addr :
                         (debug_reg == sicr_pkg::DBG_STATE)   ? dbg_bits :
                         (debug_reg == sicr_pkg::DBG_SEQ_OUT) ? observe.seq_out :
                         (debug_reg == sicr_pkg::DBG_CONV)    ? dbg_conv : 16'h0000;

  wire [31:0] rd_mux = sel_dbg  ? {16'h0000, dbg_view} :
                       sel_vec  ? {16'h0000, vector_reg} :
                       sel_ctl  ? {16'h0000, ctl1_reg} :
                       sel_stat ? {29'h0000000, stat_reg} :
                       sel_mask ? {29'h0000000, mask_reg} : 32'h00000000;

  always_comb begin
    ctl1_next = ctl1_reg;
    if (ctl_wr) begin
      ctl1_next = wdata16;
      // Software may clear flags but a write of one cannot raise them
      ctl1_next[sicr_pkg::FLAG_LSB +: NUM_FLAGS] = flags & wdata16[sicr_pkg::FLAG_LSB +: NUM_FLAGS];
      // Writing zero to the test bit cannot clear a pending test request; it stays set until test_done
      ctl1_next[sicr_pkg::TEST_BIT] = wdata16[sicr_pkg::TEST_BIT] | ctl1_reg[sicr_pkg::TEST_BIT];
    end
    if (test_done) begin
      ctl1_next[sicr_pkg::TEST_BIT] = 1'b0;
    end
    // Events win over a clearing write in the same cycle
    ctl1_next[sicr_pkg::FLAG_LSB +: NUM_FLAGS] = ctl1_next[sicr_pkg::FLAG_LSB +: NUM_FLAGS]
                                                | flag_events;
  end

  always_comb begin
    stat_next = stat_reg;
    // Cleared at the edge that captures the read data, so no event is lost in between
    if (rd_setup && sel_stat) begin
      stat_next = 3'b000;
    end
    stat_next = stat_next | stat_events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_reg <= sicr_pkg::CTL1_RESET;
      stat_reg <= sicr_pkg::STAT_RESET;
    end else begin
      ctl1_reg <= ctl1_next;
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_reg <= sicr_pkg::VECTOR_RESET;
      debug_reg  <= sicr_pkg::DEBUG_RESET;
      mask_reg   <= sicr_pkg::STAT_RESET;
    end else begin
      if (wr && sel_vec && lo_lanes) begin
        vector_reg <= wdata16;
      end
      if (wr && sel_dbg && pstrb[0]) begin
        debug_reg <= pwdata[7:0];
      end
      if (wr && sel_mask && pstrb[0]) begin
        mask_reg <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg   <= 32'h00000000;
      pready_reg   <= 1'b0;
      pslverr_reg  <= 1'b0;
      flag_irq_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      pready_reg   <= psel && !penable;
      pslverr_reg  <= psel && !penable && !mapped;
      prdata_reg   <= rd_setup ? rd_mux : 32'h00000000;
      flag_irq_reg <= ctl1_next[sicr_pkg::FLAG_LSB +: NUM_FLAGS]
                      & ctl1_next[sicr_pkg::EN_LSB +: NUM_FLAGS];
      irq_reg      <= |(stat_next & mask_reg);
    end
  end

  sicr_test_seq u_test (
    .pclk           (pclk),
    .presetn        (presetn),
    .request        (ctl1_reg[sicr_pkg::TEST_BIT] && ctl1_reg[sicr_pkg::ENABLE_BIT]),
    .cycle_boundary (cycle_boundary),
    .test_cycle_end (test_cycle_end),
    .insert_reg     (test_insert),
    .done_reg       (test_done)
  );

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign start_vector_bits  = vector_reg;
  assign scan_module_enable = ctl1_reg[sicr_pkg::ENABLE_BIT];
  assign test_cycle_insert  = test_insert;
  assign flag_irq           = flag_irq_reg;
  assign irq                = irq_reg;
  logic unused_ok;
  assign unused_ok = &{1'b0, enables, pwdata[31:16], pstrb[3:2]};
endmodule

// ---- logic/sicr_pkg.sv ----
// Package: register map, field layout and test sequencer states of the scan interface control registers
package sicr_pkg;
  localparam logic [11:0] OFF_DEBUG    = 12'h000;
  localparam logic [11:0] OFF_VECTOR   = 12'h004;
  localparam logic [11:0] OFF_CTL1     = 12'h008;
  localparam logic [11:0] OFF_STATUS   = 12'h00C;
  localparam logic [11:0] OFF_MASK     = 12'h010;
  localparam logic [7:0]  DBG_FETCH    = 8'h00;
  localparam logic [7:0]  DBG_STATE    = 8'h01;
  localparam logic [7:0]  DBG_SEQ_OUT  = 8'h02;
  localparam logic [7:0]  DBG_CONV     = 8'h03;
  localparam int          EN_LSB       = 9;
  localparam int          FLAG_LSB     = 2;
  localparam int          TEST_BIT     = 1;
  localparam int          ENABLE_BIT   = 0;
  localparam int          NUM_FLAGS    = 7;
  localparam logic [15:0] CTL1_RESET   = 16'h0000;
  localparam logic [15:0] VECTOR_RESET = 16'h0000;
  localparam logic [7:0]  DEBUG_RESET  = 8'h00;
  localparam logic [2:0]  STAT_RESET   = 3'h0;

  typedef struct packed {
    logic [15:0] fetch_addr;
    logic [4:0]  seq_index;
    logic [7:0]  state_bits;
    logic [15:0] seq_out;
    logic [2:0]  conv_index;
    logic [9:0]  conv_data;
  } sicr_observe_s;

  typedef enum logic [1:0] {
    SICR_TEST_IDLE = 2'b00,
    SICR_TEST_WAIT = 2'b01,
    SICR_TEST_RUN  = 2'b10
  } sicr_test_e;
endpackage

// ---- logic/sicr_test_seq.sv ----
// Test-cycle insertion tracker that tells when the inserted test cycle has ended
`timescale 1ns/1ps
module sicr_test_seq (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic request,
  input  wire logic cycle_boundary,
  input  wire logic test_cycle_end,
  output logic      insert_reg,
  output logic      done_reg
);
  sicr_pkg::sicr_test_e state_reg;
  sicr_pkg::sicr_test_e state_next;
  logic                 done_next;

  always_comb begin
    state_next = state_reg;
    done_next  = 1'b0;
    case (state_reg)
      sicr_pkg::SICR_TEST_IDLE: begin
        // The test bit is still set during the done pulse and must not re-arm
        if (request && !done_reg) begin
          state_next = sicr_pkg::SICR_TEST_WAIT;
        end
      end
      sicr_pkg::SICR_TEST_WAIT: begin
        // Test cycle goes in only between regular cycles
        if (!request) begin
          state_next = sicr_pkg::SICR_TEST_IDLE;
        end else if (cycle_boundary) begin
          state_next = sicr_pkg::SICR_TEST_RUN;
        end
      end
      sicr_pkg::SICR_TEST_RUN: begin
        if (test_cycle_end) begin
          state_next = sicr_pkg::SICR_TEST_IDLE;
          done_next  = 1'b1;
        end
      end
      default: begin
        state_next = sicr_pkg::SICR_TEST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= sicr_pkg::SICR_TEST_IDLE;
      insert_reg <= 1'b0;
      done_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      insert_reg <= (state_next == sicr_pkg::SICR_TEST_RUN);
      done_reg   <= done_next;
    end
  end
endmodule

// ---- tb/sicr_regs_monitor.sv ----
// Checker: port-level assertions of the scan interface control registers
`timescale 1ns/1ps
module sicr_regs_monitor #(
  parameter int NUM_FLAGS = sicr_pkg::NUM_FLAGS
) (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [NUM_FLAGS-1:0] flag_events,
  input wire logic                 cycle_boundary,
  input wire logic                 test_cycle_end,
  input wire logic [15:0]          start_vector_bits,
  input wire logic                 test_cycle_insert,
  input wire logic [NUM_FLAGS-1:0] flag_irq
);
  wire wr_acc         = psel && penable && pwrite;
  wire wr_vec         = wr_acc && paddr == sicr_pkg::OFF_VECTOR;
  wire wr_ctl         = wr_acc && paddr == sicr_pkg::OFF_CTL1;
  wire unmapped_setup = psel && !penable && paddr > sicr_pkg::OFF_MASK;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  chk_ready_after_setup: assert property (s_setup ##1 s_access |-> pready)
    else $error("no ready in access phase");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_unmapped_err: assert property (unmapped_setup |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  chk_vector_hold:
    assert property (!$stable(start_vector_bits) |-> $past(wr_vec))
    else $error("vector changed without a write");
  chk_flag_sticky:
    assert property ($fell(flag_irq[0]) |-> $past(wr_ctl))
    else $error("flag request dropped without a write");
  chk_flag_cause:
    assert property ($rose(flag_irq[0]) |-> $past(flag_events[0]) || $past(wr_ctl))
    else $error("flag request raised without cause");
  chk_test_start:
    assert property ($rose(test_cycle_insert) |-> $past(cycle_boundary) || $past(cycle_boundary, 2))
    else $error("test cycle began off a cycle boundary");
  chk_test_end:
    assert property ($fell(test_cycle_insert) |-> $past(test_cycle_end) || $past(test_cycle_end, 2))
    else $error("test cycle ended without its end pulse");
endmodule
bind sicr_regs sicr_regs_monitor #(.NUM_FLAGS(NUM_FLAGS)) i_sicr_regs_monitor (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .flag_events(flag_events),
  .cycle_boundary(cycle_boundary), .test_cycle_end(test_cycle_end),
  .start_vector_bits(start_vector_bits), .test_cycle_insert(test_cycle_insert),
  .flag_irq(flag_irq));

// ---- tb/sicr_regs_tb.sv ----
// Self-checking testbench of the scan interface control registers
`timescale 1ns/1ps
module sicr_regs_tb;
  logic                    pclk, presetn, psel, penable, pwrite, err;
  logic                    cycle_boundary, test_cycle_end, pready, pslverr, irq;
  logic                    scan_module_enable, test_cycle_insert;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rq;
  logic [15:0]             start_vector_bits;
  logic [6:0]              flag_events, flag_irq;
  sicr_pkg::sicr_observe_s observe;
  int                      failures = 0;
  int                      n_checks = 0;
  sicr_regs i_sicr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .observe(observe), .flag_events(flag_events),
    .cycle_boundary(cycle_boundary), .test_cycle_end(test_cycle_end),
    .start_vector_bits(start_vector_bits), .scan_module_enable(scan_module_enable),
    .test_cycle_insert(test_cycle_insert), .flag_irq(flag_irq), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request stands until pready is sampled high at a rising edge; data is taken there
  task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq  = prdata;
    err = pslverr;
    chk("pready", 32'h1, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 16'h0000);
    chk(nm, exp, rq);
  endtask
  task automatic pulse(input logic [6:0] f, input logic b, input logic e);
    @(posedge pclk);
    flag_events    <= f;
    cycle_boundary <= b;
    test_cycle_end <= e;
    @(posedge pclk);
    flag_events    <= 7'h00;
    cycle_boundary <= 1'b0;
    test_cycle_end <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic t_reset_and_vector();
    rd(sicr_pkg::OFF_CTL1, 32'h0, "ctl1 reset");
    chk("outputs reset", 32'h0, {scan_module_enable, test_cycle_insert, flag_irq, irq});
    apb(1'b1, sicr_pkg::OFF_VECTOR, 16'hA5C3);
    rd(sicr_pkg::OFF_VECTOR, 32'h0000A5C3, "vector");
    chk("vector port", 32'h0000A5C3, {16'h0000, start_vector_bits});
    $display("t_reset_and_vector done");
  endtask
  task automatic t_debug();
    apb(1'b1, sicr_pkg::OFF_DEBUG, 16'h0003);
    rd(sicr_pkg::OFF_DEBUG, 32'h000062A5, "debug conv");
    observe.conv_index <= 3'h1;
    rd(sicr_pkg::OFF_DEBUG, 32'h000012A5, "debug conv again");
    apb(1'b1, sicr_pkg::OFF_DEBUG, 16'h0001);
    rd(sicr_pkg::OFF_DEBUG, 32'h00000A5B, "debug state bits");
    apb(1'b1, sicr_pkg::OFF_DEBUG, 16'h0002);
    rd(sicr_pkg::OFF_DEBUG, 32'h0000BEEF, "debug seq out");
    apb(1'b1, sicr_pkg::OFF_DEBUG, 16'h0004);
    rd(sicr_pkg::OFF_DEBUG, 32'h00000000, "debug unused mode");
    apb(1'b1, sicr_pkg::OFF_DEBUG, 16'h0000);
    rd(sicr_pkg::OFF_DEBUG, 32'h00001234, "debug addr");
    $display("t_debug done");
  endtask
  task automatic t_flags();
    apb(1'b1, sicr_pkg::OFF_CTL1, 16'h0201);
    @(posedge pclk);
    chk("enable", 32'h1, {31'h0, scan_module_enable});
    apb(1'b1, sicr_pkg::OFF_MASK, 16'h0001);
    apb(1'b0, sicr_pkg::OFF_STATUS, 16'h0000);
    pulse(7'h03, 1'b0, 1'b0);
    chk("flag_irq", 32'h1, {25'h0, flag_irq});
    chk("irq", 32'h1, {31'h0, irq});
    rd(sicr_pkg::OFF_CTL1, 32'h0000020D, "ctl1 flags held");
    rd(sicr_pkg::OFF_STATUS, 32'h1, "status");
    repeat (2) @(posedge pclk);
    chk("irq after read", 32'h0, {31'h0, irq});
    apb(1'b1, sicr_pkg::OFF_MASK, 16'h0000);
    pulse(7'h01, 1'b0, 1'b0);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, sicr_pkg::OFF_CTL1, 16'h0201);
    rd(sicr_pkg::OFF_CTL1, 32'h00000201, "ctl1 cleared");
    chk("flag_irq cleared", 32'h0, {25'h0, flag_irq});
    $display("t_flags done");
  endtask
  task automatic t_test_cycle();
    apb(1'b1, sicr_pkg::OFF_CTL1, 16'h0003);
    repeat (2) @(posedge pclk);
    chk("no insert yet", 32'h0, {31'h0, test_cycle_insert});
    pulse(7'h00, 1'b1, 1'b0);
    chk("insert", 32'h1, {31'h0, test_cycle_insert});
    rd(sicr_pkg::OFF_CTL1, 32'h00000003, "test bit held");
    pulse(7'h00, 1'b0, 1'b1);
    rd(sicr_pkg::OFF_CTL1, 32'h00000001, "test bit cleared");
    chk("insert ended", 32'h0, {31'h0, test_cycle_insert});
    apb(1'b1, sicr_pkg::OFF_CTL1, 16'h0000);
    @(posedge pclk);
    chk("disable", 32'h0, {31'h0, scan_module_enable});
    apb(1'b0, 12'h100, 16'h0000);
    chk("unmapped", 32'h1, {rq[30:0], err});
    rd(sicr_pkg::OFF_STATUS, 32'h00000007, "status events");
    rd(sicr_pkg::OFF_STATUS, 32'h00000000, "status cleared");
    $display("t_test_cycle done");
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    wrap_up();
  end
  initial begin
    {presetn, psel, penable, pwrite, cycle_boundary, test_cycle_end} = 6'h00;
    {paddr, pwdata, flag_events} = 51'h0;
    observe = '{fetch_addr: 16'h1234, seq_index: 5'h0A, state_bits: 8'h5B, seq_out: 16'hBEEF,
      conv_index: 3'h6, conv_data: 10'h2A5};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_and_vector();
    t_debug();
    t_flags();
    t_test_cycle();
    wrap_up();
  end
endmodule
